// [core/fdvw_pkg.sv]
// Constants and types shared by the verify/write/version command block.
package fdvw_pkg;
  localparam logic [4:0] OP_VERIFY       = 5'h16;
  localparam logic [5:0] OP_WRITE        = 6'h05;
  localparam logic [7:0] OP_VERSION      = 8'h10;
  localparam logic [7:0] VERSION_ID      = 8'h5A; // Arbitrary identification value.
  localparam logic [7:0] INVALID_RESULT  = 8'h80;
  localparam logic [3:0] CMD_LEN         = 4'h9;
  localparam int         B_OPC           = 0;
  localparam int         B_DRV           = 1;
  localparam int         B_TRK           = 2;
  localparam int         B_HEAD          = 3;
  localparam int         B_SEC           = 4;
  localparam int         B_SIZE          = 5;
  localparam int         B_EOT           = 6;
  localparam int         B_SC            = 8;
  localparam int         OPC_MT          = 7;
  localparam int         DRV_EXT         = 7;
  localparam int         DRV_HEAD        = 2;
  localparam logic [1:0] IC_NORMAL       = 2'h0;
  localparam logic [1:0] IC_ABNORMAL     = 2'h1;
  localparam int         ST1_MISS_AM     = 0;
  localparam int         ST1_MISS_DATA   = 2;
  localparam int         ST2_WRONG_TRK   = 4;
  localparam int         ST2_BAD_TRK     = 1;
  localparam logic [7:0] BAD_TRACK_ID    = 8'hFF;
  localparam logic [2:0] RES_LEN         = 3'h7;
  localparam logic [1:0] INDEX_LIMIT     = 2'h2;
  localparam logic [7:0] DBP_ZERO_FACTOR = 8'h80;
  localparam int         DBP_UNIT_US     = 1000;
  localparam int         CLK_HZ          = 25000000;
  localparam int         FIFO_W          = 8;
  localparam int         FIFO_D          = 16;
  typedef enum logic [2:0] {
    S_IDLE  = 3'h0,
    S_CMD   = 3'h1,
    S_DELAY = 3'h2,
    S_SEEK  = 3'h3,
    S_SRCH  = 3'h4,
    S_DATA  = 3'h5,
    S_RES   = 3'h6,
    S_DRAIN = 3'h7
  } fdvw_state_t;
endpackage

// [core/fdvw_core.sv]
// Verify, version and write data command interpreter with its result FIFO.
// Operation
// - Verify checks ID and data marks, no host data.
// - Multi-track verify continues onto side one.
// - Seven result bytes: three status, track, head, sector, size.
// - Count disabled: last sector beyond side aborts.
// - Count enabled single side: count checked against limits.
// - Multi-track counted: twice last sector allowed.
// - Version returns one fixed identification byte.
// - Write waits delay before processing first.
// - Implied seek on write performed internally when enabled.
// - Host write bytes are written to disk.
// - Separator on, compare IDs until match.
// - Search error sets abnormal code, enters result.
// - Host byte during execution aborts the command.
// - Two index pulses without match end in error.
// - Track mismatch sets wrong or bad track.
// - Head, sector or size mismatch sets missing data.
// - No address mark sets missing mark flag.
// - Counted verify stops at count, zero means 256.
// - Uncounted verify stops at last sector number.
// - Interrupt code normal 00, abnormal 01.
// - Interrupt line marks result phase of a transfer.
module fdvw_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         core_clk_in,
  input  wire logic         sys_rst_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;
  assign in_ready_out  = (cnt_r != (AW+1)'(D));
  assign out_valid_out = (cnt_r != '0);
  assign out_data_out  = mem_r[rp_r];
  assign push = in_valid_in && in_ready_out;
  assign pop  = out_valid_out && out_ready_in;
  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem_r[wp_r] <= in_data_in;
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= push ? wp_r + 1'b1 : wp_r;
      rp_r  <= pop ? rp_r + 1'b1 : rp_r;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module fdvw_core
  import fdvw_pkg::*;
#(
  parameter int UNIT_CYCLES = DBP_UNIT_US * (CLK_HZ / 1000000)
) (
  input  wire logic                  core_clk_in,
  input  wire logic                  sys_rst_in,
  input  wire logic                  cmd_valid_in,
  input  wire logic [7:0]            cmd_data_in,
  output logic                       cmd_ready_out,
  output logic                       res_valid_out,
  output logic [fdvw_pkg::FIFO_W-1:0] res_data_out,
  input  wire logic                  res_ready_in,
  input  wire logic                  wr_valid_in,
  input  wire logic [7:0]            wr_data_in,
  output logic                       wr_ready_out,
  output logic                       disk_wr_valid_out,
  output logic [7:0]                 disk_wr_data_out,
  input  wire logic                  disk_wr_ready_in,
  input  wire logic [3:0]            dbp_factor_in,
  input  wire logic [7:0]            sectors_per_side_in,
  input  wire logic                  index_pin_in,
  output logic                       separator_en_out,
  input  wire logic                  id_valid_in,
  input  wire logic [7:0]            id_track_in,
  input  wire logic [7:0]            id_head_in,
  input  wire logic [7:0]            id_sector_in,
  input  wire logic [7:0]            id_size_in,
  input  wire logic                  data_am_ok_in,
  input  wire logic                  am_missing_in,
  output logic                       seek_req_out,
  output logic [7:0]                 seek_track_out,
  input  wire logic                  seek_done_in,
  output logic                       fdc_interrupt_line_out
);
  import fdvw_pkg::*;
  fdvw_state_t state_r;
  logic [7:0]  cb_r [9];
  logic [3:0]  cidx_r;
  logic        is_write_r;
  logic        is_ver_r;
  logic [7:0]  head_r;
  logic [7:0]  sec_r;
  logic [8:0]  done_r;
  logic [1:0]  ic_r;
  logic [7:0]  st1_r;
  logic [7:0]  st2_r;
  logic [1:0]  idx_cnt_r;
  logic [2:0]  ridx_r;
  logic [7:0]  fcnt_r;
  logic [31:0] ucnt_r;
  logic [14:0] bleft_r;
  logic        seek_sent_r;
  logic [2:0]  isync_r;
  logic        ifilt_r;
  logic        index_rise;
  logic        cmd_fire;
  logic        exec;
  logic        wr_fire;
  logic        f_ready;
  logic        f_push;
  logic [7:0]  f_data;
  logic        id_match;
  logic        mt;
  logic        ec;
  logic [8:0]  sc_eff;
  logic [8:0]  eot9;
  logic [8:0]  spp9;
  logic        param_bad;
  logic        trk_end;
  logic [3:0]  op_len;
  logic        sect_done;

  assign exec     = state_r inside {S_DELAY, S_SEEK, S_SRCH, S_DATA};
  assign cmd_ready_out = state_r inside {S_IDLE, S_CMD} || exec;
  assign cmd_fire = cmd_valid_in && cmd_ready_out;
  assign mt       = cb_r[B_OPC][OPC_MT];
  assign ec       = cb_r[B_DRV][DRV_EXT];
  assign sc_eff   = (cb_r[B_SC] == 8'h00) ? 9'h100 : {1'b0, cb_r[B_SC]};
  assign eot9     = {1'b0, cb_r[B_EOT]};
  assign spp9     = {1'b0, sectors_per_side_in};
  // Verify limits are judged once before the first sector, so a bad setup costs no revolution; write skips them.
  always_comb begin
    if (!ec) begin
      param_bad = eot9 > spp9;
    end else if (!mt) begin
      param_bad = !(sc_eff <= spp9 && sc_eff <= eot9);
    end else begin
      param_bad = !((sc_eff <= spp9 && sc_eff <= eot9) ||
                    (sc_eff <= {eot9[7:0], 1'b0} && eot9 <= spp9));
    end
  end
  assign op_len = (cidx_r == 4'h0 && cmd_data_in == OP_VERSION) ? 4'h1 : CMD_LEN;
  assign id_match = id_track_in == cb_r[B_TRK] && id_head_in == head_r &&
                    id_sector_in == sec_r && id_size_in == cb_r[B_SIZE];
  assign trk_end  = sec_r == cb_r[B_EOT] && (!mt || head_r[0]);
  assign wr_ready_out = state_r == S_DATA && is_write_r &&
                        (!disk_wr_valid_out || disk_wr_ready_in);
  assign wr_fire  = wr_valid_in && wr_ready_out;
  assign sect_done = is_write_r ? (wr_fire && bleft_r == 15'h1)
                                : (state_r == S_DATA && data_am_ok_in);
  assign separator_en_out = state_r inside {S_SRCH, S_DATA};
  assign seek_req_out   = state_r == S_SEEK && !seek_sent_r;
  assign seek_track_out = cb_r[B_TRK];
  assign fdc_interrupt_line_out = state_r inside {S_RES, S_DRAIN} && !is_ver_r;

  // The first stage feeds only the second; only agreed later stages move the filter.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      isync_r <= 3'h0;
      ifilt_r <= 1'b0;
    end else begin
      isync_r <= {isync_r[1:0], index_pin_in};
      if (isync_r[1] == isync_r[2]) begin
        ifilt_r <= isync_r[2];
      end
    end
  end
  assign index_rise = isync_r[1] == isync_r[2] && isync_r[2] && !ifilt_r;

  always_ff @(posedge core_clk_in) begin
    if (cmd_fire && state_r inside {S_IDLE, S_CMD}) begin
      cb_r[cidx_r] <= cmd_data_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state_r     <= S_IDLE;
      cidx_r      <= 4'h0;
      is_write_r  <= 1'b0;
      is_ver_r    <= 1'b0;
      ic_r        <= IC_NORMAL;
      st1_r       <= 8'h00;
      st2_r       <= 8'h00;
      head_r      <= 8'h00;
      sec_r       <= 8'h00;
      done_r      <= 9'h000;
      idx_cnt_r   <= 2'h0;
      ridx_r      <= 3'h0;
      fcnt_r      <= 8'h00;
      ucnt_r      <= 32'h0;
      bleft_r     <= 15'h0;
      seek_sent_r <= 1'b0;
    end else begin
      unique case (state_r)
        S_IDLE, S_CMD: begin
          if (cmd_fire) begin
            if (cidx_r == 4'h0) begin
              is_ver_r   <= cmd_data_in == OP_VERSION;
              is_write_r <= cmd_data_in[5:0] == OP_WRITE;
            end
            if (cidx_r + 4'h1 == op_len) begin
              cidx_r <= 4'h0;
              ridx_r <= 3'h0;
              ic_r   <= IC_NORMAL;
              st1_r  <= 8'h00;
              st2_r  <= 8'h00;
              done_r <= 9'h000;
              if (op_len == 4'h1) begin
                state_r <= S_RES;
              end else if (cb_r[B_OPC][5:0] == OP_WRITE) begin
                fcnt_r  <= (dbp_factor_in == 4'h0) ? DBP_ZERO_FACTOR : {4'h0, dbp_factor_in};
                ucnt_r  <= 32'h0;
                state_r <= S_DELAY;
              end else if (cb_r[B_OPC][4:0] == OP_VERIFY) begin
                state_r <= S_SEEK;
              end else begin
                is_ver_r <= 1'b1;
                ic_r     <= IC_ABNORMAL;
                state_r  <= S_RES;
              end
              head_r      <= {7'h0, cb_r[B_DRV][DRV_HEAD]};
              sec_r       <= cb_r[B_SEC];
              seek_sent_r <= 1'b0;
            end else begin
              cidx_r  <= cidx_r + 4'h1;
              state_r <= S_CMD;
            end
          end
        end
        S_DELAY: begin
          if (ucnt_r == 32'(UNIT_CYCLES - 1)) begin
            ucnt_r <= 32'h0;
            fcnt_r <= fcnt_r - 8'h01;
            if (fcnt_r == 8'h01) begin
              state_r <= S_SEEK;
            end
          end else begin
            ucnt_r <= ucnt_r + 32'h1;
          end
        end
        S_SEEK: begin
          seek_sent_r <= 1'b1;
          if (!cb_r[B_DRV][DRV_EXT] || !is_write_r || seek_done_in) begin
            idx_cnt_r <= 2'h0;
            if (!is_write_r && param_bad) begin
              ic_r    <= IC_ABNORMAL;
              state_r <= S_RES;
            end else begin
              state_r <= S_SRCH;
            end
          end
        end
        S_SRCH: begin
          if (am_missing_in) begin
            st1_r[ST1_MISS_AM] <= 1'b1;
            ic_r    <= IC_ABNORMAL;
            state_r <= S_RES;
          end else if (index_rise && idx_cnt_r == INDEX_LIMIT - 2'h1) begin
            ic_r    <= IC_ABNORMAL;
            state_r <= S_RES;
          end else if (id_valid_in) begin
            if (id_match) begin
              bleft_r <= 15'h80 << id_size_in[2:0];
              st1_r   <= 8'h00;
              st2_r   <= 8'h00;
              state_r <= S_DATA;
            end else if (id_track_in != cb_r[B_TRK]) begin
              if (id_track_in == BAD_TRACK_ID) begin
                st2_r[ST2_BAD_TRK] <= 1'b1;
              end else begin
                st2_r[ST2_WRONG_TRK] <= 1'b1;
              end
            end else begin
              st1_r[ST1_MISS_DATA] <= 1'b1;
            end
          end
          if (index_rise) begin
            idx_cnt_r <= idx_cnt_r + 2'h1;
          end
        end
        S_DATA: begin
          if (wr_fire) begin
            bleft_r <= bleft_r - 15'h1;
          end
          if (!is_write_r && am_missing_in) begin
            st1_r[ST1_MISS_AM] <= 1'b1;
            ic_r    <= IC_ABNORMAL;
            state_r <= S_RES;
          end else if (sect_done) begin
            done_r    <= done_r + 9'h001;
            idx_cnt_r <= 2'h0;
            if (!is_write_r && ec && done_r + 9'h001 == sc_eff) begin
              state_r <= S_RES;
            end else if (trk_end) begin
              ic_r    <= (!is_write_r && ec) ? IC_ABNORMAL : IC_NORMAL;
              state_r <= S_RES;
            end else if (sec_r == cb_r[B_EOT]) begin
              head_r  <= 8'h01;
              sec_r   <= 8'h01;
              state_r <= S_SRCH;
            end else begin
              sec_r   <= sec_r + 8'h01;
              state_r <= S_SRCH;
            end
          end
        end
        S_RES: begin
          if (f_ready) begin
            ridx_r <= ridx_r + 3'h1;
            if (is_ver_r || ridx_r == RES_LEN - 3'h1) begin
              state_r <= S_DRAIN;
            end
          end
        end
        S_DRAIN: begin
          if (!res_valid_out) begin
            state_r <= S_IDLE;
          end
        end
      endcase
      // A host byte in execution is an abort; it also frees a drive with no disk.
      if (exec && cmd_fire) begin
        ic_r    <= IC_ABNORMAL;
        state_r <= S_RES;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      disk_wr_valid_out <= 1'b0;
      disk_wr_data_out  <= 8'h00;
    end else if (wr_fire) begin
      disk_wr_valid_out <= 1'b1;
      disk_wr_data_out  <= wr_data_in;
    end else if (disk_wr_ready_in) begin
      disk_wr_valid_out <= 1'b0;
    end
  end

  always_comb begin
    f_data = 8'h00;
    if (is_ver_r) begin
      f_data = (ic_r == IC_NORMAL) ? VERSION_ID : INVALID_RESULT;
    end else begin
      unique case (ridx_r)
        3'h0: f_data = {ic_r, 3'h0, head_r[0], cb_r[B_DRV][1:0]};
        3'h1: f_data = st1_r;
        3'h2: f_data = st2_r;
        3'h3: f_data = cb_r[B_TRK];
        3'h4: f_data = head_r;
        3'h5: f_data = sec_r;
        3'h6: f_data = cb_r[B_SIZE];
        default: f_data = 8'h00;
      endcase
    end
  end
  assign f_push = state_r == S_RES;

  fdvw_fifo #(.W(FIFO_W), .D(FIFO_D)) u_res_fifo (
    .core_clk_in   (core_clk_in),
    .sys_rst_in    (sys_rst_in),
    .in_valid_in   (f_push),
    .in_ready_out  (f_ready),
    .in_data_in    (f_data),
    .out_valid_out (res_valid_out),
    .out_ready_in  (res_ready_in),
    .out_data_out  (res_data_out)
  );

  a_abort_exec: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    exec && cmd_fire |=> state_r == S_RES && ic_r == IC_ABNORMAL)
    else $error("Host byte in execution did not abort.");
  a_index_limit: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    state_r == S_SRCH && !cmd_fire && !am_missing_in && index_rise && idx_cnt_r == 2'h1
    |=> state_r == S_RES && ic_r == IC_ABNORMAL)
    else $error("Second index pulse did not end the search.");
  a_wrong_track: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    state_r == S_SRCH && id_valid_in && !am_missing_in && !index_rise &&
    id_track_in != cb_r[B_TRK] && id_track_in != BAD_TRACK_ID |=> st2_r[ST2_WRONG_TRK])
    else $error("Wrong track flag missing.");
  a_bad_track: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    state_r == S_SRCH && id_valid_in && !am_missing_in && !index_rise &&
    cb_r[B_TRK] != BAD_TRACK_ID && id_track_in == BAD_TRACK_ID |=> st2_r[ST2_BAD_TRK])
    else $error("Bad track flag missing.");
  a_missing_data: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    state_r == S_SRCH && id_valid_in && !am_missing_in && !index_rise && !id_match &&
    id_track_in == cb_r[B_TRK] |=> st1_r[ST1_MISS_DATA])
    else $error("Missing data flag not set on ID mismatch.");
  a_missing_am: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    state_r == S_SRCH && am_missing_in |=> st1_r[ST1_MISS_AM] && ic_r == IC_ABNORMAL)
    else $error("Missing mark flag not set.");
  a_irq_result: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    $rose(state_r == S_RES) && !is_ver_r |-> fdc_interrupt_line_out [*2])
    else $error("Interrupt line not raised for result phase.");
  a_side_switch: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    state_r == S_DATA && !is_write_r && sect_done && mt && !cmd_fire && !am_missing_in &&
    (!ec || done_r + 9'h001 != sc_eff) && head_r == 8'h00 && sec_r == cb_r[B_EOT]
    |=> head_r == 8'h01 && sec_r == 8'h01)
    else $error("Multi-track verify did not move to side one.");
  a_seven_bytes: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    $fell(state_r == S_RES) && !is_ver_r |-> ridx_r == RES_LEN)
    else $error("Result phase did not push seven bytes.");
  c_verify_done: cover property (@(posedge core_clk_in) disable iff (sys_rst_in)
    state_r == S_DATA && !is_write_r && sect_done);
  c_write_sector: cover property (@(posedge core_clk_in) disable iff (sys_rst_in)
    state_r == S_DATA && is_write_r && sect_done);
  c_version: cover property (@(posedge core_clk_in) disable iff (sys_rst_in)
    state_r == S_RES && is_ver_r && f_ready);
  c_abort: cover property (@(posedge core_clk_in) disable iff (sys_rst_in) exec && cmd_fire);
endmodule

// [verification/fdvw_dma_model.sv]
// Host DMA source and drive write sink around the write data path.
module fdvw_dma_model (
  input  wire logic        core_clk_in,
  input  wire logic        sys_rst_in,
  output logic             wr_valid_out,
  output logic [7:0]       wr_data_out,
  input  wire logic        wr_ready_in,
  input  wire logic        disk_wr_valid_in,
  input  wire logic [7:0]  disk_wr_data_in,
  output logic             disk_wr_ready_out,
  output logic [15:0]      disk_count_out,
  output logic             order_bad_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Each byte is held until the device takes it, as a DMA channel would.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      wr_valid_out <= 1'b0;
      wr_data_out <= 8'h00;
    end else begin
      wr_valid_out <= 1'b1;
      if (wr_valid_out && wr_ready_in) wr_data_out <= wr_data_out + 8'h01;
    end
  end
  // The drive stalls every other cycle so the device must hold its byte.
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      disk_wr_ready_out <= 1'b0;
      disk_count_out <= 16'h0000;
      order_bad_out <= 1'b0;
    end else begin
      disk_wr_ready_out <= ~disk_wr_ready_out;
      if (disk_wr_valid_in && disk_wr_ready_out) begin
        disk_count_out <= disk_count_out + 16'h0001;
        if (disk_wr_data_in !== disk_count_out[7:0]) order_bad_out <= 1'b1;
      end
    end
  end
endmodule

// [verification/fdvw_core_bench.sv]
// Self-checking bench for the verify, version and write command block.
module fdvw_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import fdvw_pkg::*;
  logic clk = 1'b0, rst = 1'b1, cv = 1'b0, cr, rv, rr = 1'b0, wv, wr, dv, drd, idx = 1'b0;
  logic sep, sq, sd = 1'b0, irq, iv = 1'b0, amok = 1'b0, amx = 1'b0, bad;
  logic [7:0] cd = 8'h00, rd, wd, dd, st, it = 8'h00, ih = 8'h00, is = 8'h01, iz = 8'h00;
  logic [15:0] dcnt;
  logic [7:0] rb[7];
  int failures = 0, cmp_count = 0;
  logic [7:0] vo[3] = '{8'h56, 8'h56, 8'hD6}, vd[3] = '{8'h06, 8'h86, 8'h86};
  logic [7:0] ve[3] = '{8'h09, 8'h08, 8'h04}, vs[3] = '{8'hFF, 8'h09, 8'h09};
  logic [7:0] wt[5] = '{8'h04, 8'hFF, 8'h03, 8'h03, 8'h03};
  logic [7:0] wh[5] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
  logic [7:0] e1[5] = '{8'h00, 8'h00, 8'h04, 8'h01, 8'h00};
  logic [7:0] e2[5] = '{8'h10, 8'h02, 8'h00, 8'h00, 8'h00};
  always #20 clk = ~clk;
  fdvw_core #(.UNIT_CYCLES(4)) dut_u (.core_clk_in(clk), .sys_rst_in(rst),
    .cmd_valid_in(cv), .cmd_data_in(cd), .cmd_ready_out(cr), .res_valid_out(rv),
    .res_data_out(rd), .res_ready_in(rr), .wr_valid_in(wv), .wr_data_in(wd),
    .wr_ready_out(wr), .disk_wr_valid_out(dv), .disk_wr_data_out(dd),
    .disk_wr_ready_in(drd), .dbp_factor_in(4'h1), .sectors_per_side_in(8'h08),
    .index_pin_in(idx), .separator_en_out(sep), .id_valid_in(iv), .id_track_in(it),
    .id_head_in(ih), .id_sector_in(is), .id_size_in(iz), .data_am_ok_in(amok),
    .am_missing_in(amx), .seek_req_out(sq), .seek_track_out(st), .seek_done_in(sd),
    .fdc_interrupt_line_out(irq));
  fdvw_dma_model host_u (.core_clk_in(clk), .sys_rst_in(rst), .wr_valid_out(wv),
    .wr_data_out(wd), .wr_ready_in(wr), .disk_wr_valid_in(dv), .disk_wr_data_in(dd),
    .disk_wr_ready_out(drd), .disk_count_out(dcnt), .order_bad_out(bad));
  task wrap_up;
    if (failures == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
    cmp_count++;
    if ((got & m) !== (exp & m)) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // A wait that runs out of its bound ends the run as a failure.
  task stop;
    failures++;
    wrap_up();
  endtask
  task put(input logic [7:0] b);
    int n;
    n = 0;
    @(negedge clk);
    cv = 1'b1;
    cd = b;
    while (cr !== 1'b1) begin
      n++;
      if (n > 200) stop();
      @(negedge clk);
    end
    @(posedge clk);
  endtask
  task cmd9(input logic [7:0] o, d, t, h, s, z, e, c);
    put(o); put(d); put(t); put(h); put(s); put(z); put(e); put(8'h1B); put(c);
    @(negedge clk);
    cv = 1'b0;
  endtask
  task get(input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      k = 0;
      @(negedge clk);
      while (rv !== 1'b1) begin
        k++;
        if (k > 4000) stop();
        @(negedge clk);
      end
      rb[i] = rd;
      rr = 1'b1;
      @(posedge clk);
      @(negedge clk);
      rr = 1'b0;
    end
    chk({7'h00, rv}, 8'h00, 8'hFF);
  endtask
  task idp(input logic [7:0] t, h);
    @(negedge clk);
    iv = 1'b1; it = t; ih = h;
    @(negedge clk);
    iv = 1'b0;
  endtask
  task wseek;
    int k;
    k = 0;
    while (sq !== 1'b1) begin
      k++;
      if (k > 200) stop();
      @(negedge clk);
    end
    chk(8'(k), 8'h04, 8'hFF);
    chk(st, 8'h03, 8'hFF);
    // The seek is held back so the search must wait for its completion.
    repeat (2) @(negedge clk);
    chk({7'h00, sep}, 8'h00, 8'hFF);
    sd = 1'b1;
    @(negedge clk);
    sd = 1'b0;
    repeat (3) @(negedge clk);
    chk({7'h00, sep}, 8'h01, 8'hFF);
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    put(OP_VERSION);
    @(negedge clk);
    cv = 1'b0;
    get(1);
    chk(rb[0], VERSION_ID, 8'hFF);
    for (int i = 0; i < 3; i++) begin
      cmd9(vo[i], vd[i], 8'h03, 8'h01, 8'h01, 8'h02, ve[i], vs[i]);
      get(7);
      chk(rb[0], 8'h46, 8'hFF);
      chk(rb[3], 8'h03, 8'hFF);
      chk(rb[6], 8'h02, 8'hFF);
    end
    // Counted multi-track verify must cross to side one before it ends.
    cmd9(8'hD6, 8'h80, 8'h03, 8'h00, 8'h01, 8'h02, 8'h01, 8'h02);
    iz = 8'h02;
    repeat (4) @(negedge clk);
    idp(8'h03, 8'h00);
    amok = 1'b1;
    @(negedge clk);
    amok = 1'b0;
    repeat (3) @(negedge clk);
    chk({7'h00, rv}, 8'h00, 8'hFF);
    idp(8'h03, 8'h01);
    amok = 1'b1;
    @(negedge clk);
    amok = 1'b0;
    get(7);
    chk(rb[0], 8'h00, 8'hC0);
    cmd9(8'h56, 8'h00, 8'h03, 8'h00, 8'h01, 8'h02, 8'h01, 8'hFF);
    repeat (4) @(negedge clk);
    idp(8'h03, 8'h00);
    amok = 1'b1;
    @(negedge clk);
    amok = 1'b0;
    get(7);
    chk(rb[0], 8'h00, 8'hFF);
    chk(rb[5], 8'h01, 8'hFF);
    iz = 8'h00;
    for (int i = 0; i < 5; i++) begin
      cmd9(8'h45, 8'h80, 8'h03, 8'h00, 8'h01, 8'h00, 8'h01, 8'hFF);
      wseek();
      if (i < 3) idp(wt[i], wh[i]);
      if (i == 3) amx = 1'b1;
      @(negedge clk);
      amx = 1'b0;
      if (i == 4) put(8'h00);
      @(negedge clk);
      cv = 1'b0;
      repeat (2) begin
        idx = 1'b1;
        repeat (6) @(negedge clk);
        idx = 1'b0;
        repeat (6) @(negedge clk);
      end
      get(7);
      chk(rb[0], 8'h40, 8'hFF);
      chk(rb[1], e1[i], 8'hFF);
      chk(rb[2], e2[i], 8'hFF);
    end
    cmd9(8'h45, 8'h80, 8'h03, 8'h00, 8'h01, 8'h00, 8'h01, 8'hFF);
    wseek();
    idp(8'h03, 8'h00);
    get(0);
    for (int k = 0; rv !== 1'b1; k++) begin
      if (k > 2000) stop();
      @(negedge clk);
    end
    chk({7'h00, irq}, 8'h01, 8'hFF);
    get(7);
    chk(rb[0], 8'h00, 8'hC0);
    chk(dcnt[7:0], 8'h80, 8'hFF);
    chk({7'h00, bad}, 8'h00, 8'hFF);
    @(negedge clk);
    chk({7'h00, irq}, 8'h00, 8'hFF);
    wrap_up();
  end
endmodule
